// *** dv/shift_hold_sequencer_tb.sv ***
/*
  bench for the shift-hold sequencer: zero-count and unequal-scale holds.
  assumes capture at T2.2, so one hold episode spans 32 edges.
*/
`timescale 1ns/1ps
`default_nettype none
module shift_hold_sequencer_tb;
  import shseq_pkg::*;
  logic sysClk = 1'b0;
  logic nrst = 1'b0;
  logic iSeq = 1'b0;
  logic [11:0] funcCode = 12'h000;
  logic [35:0] instrWord = 36'h0;
  logic [35:0] accum = 36'h0;
  logic stepA, stepB, stepC, scale, rel, st1, st2, fEn;
  logic [5:0] wCnt;
  logic [11:0] hFunc;
  logic [4:0] expQ[$];
  logic [4:0] last = 5'h00;
  logic [4:0] obs;
  integer seed = 4;
  integer fails = 0;
  integer checkCount = 0;
  always #12.5 sysClk = ~sysClk;
  shseq_top dut (.sys_clk(sysClk), .nrst(nrst), .iSeq(iSeq), .funcCode(funcCode),
    .instrWord(instrWord), .accum(accum), .shiftStepA(stepA), .shiftStepB(stepB),
    .shiftStepC(stepC), .scaleFactor(scale), .stallRelease(rel), .fetchStallFirst(st1),
    .fetchStallSecond(st2), .fetchEnable(fEn), .shiftPulse(), .workingCount(wCnt),
    .heldFunc(hFunc));
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  // expected {st1, st2, stepB, stepC, rel} after each change
  task automatic run_one(input logic [11:0] f, input logic d);
    logic sc;
    sc = d && f === SHSEQ_F_5044;
    funcCode = f;
    instrWord = {$random(seed), 4'h0} & 36'hFFFFFFFC0;
    accum = {$random(seed), 4'h0};
    accum[35:34] = {1'b1, ~d};
    expQ.push_back(5'h10);
    if (sc) begin
      expQ.push_back(5'h18);
      expQ.push_back(5'h19);
    end else begin
      expQ.push_back(5'h14);
      expQ.push_back(5'h1E);
      expQ.push_back(5'h1B);
      expQ.push_back(5'h19);
    end
    expQ.push_back(5'h09);
    expQ.push_back(5'h08);
    expQ.push_back(5'h00);
    repeat (8) @(negedge sysClk);
    // new word after capture, before the hold starts, must be ignored
    accum = {$random(seed), 4'hF};
    instrWord = {$random(seed), 4'h1};
    funcCode = instrWord[11:0];
    repeat (24) @(negedge sysClk);
    $display("episode %h unequal %0d done", f, sc);
  endtask : run_one
  // monitor: every change of the hold state consumes one note
  always @(posedge sysClk) begin
    #1;
    obs = {st1, st2, stepB, stepC, rel};
    if (obs !== last) begin
      check({7'h00, obs}, expQ.size() > 0 ? {7'h00, expQ.pop_front()} : 12'hFFF, "hold");
    end
    last = obs;
  end
  initial begin
    repeat (16) @(negedge sysClk);
    nrst = 1'b1;
    iSeq = 1'b1;
    for (int i = 0; i < 10; i++) begin
      run_one(i < 2 ? SHSEQ_F_5026 + 12'(i) : SHSEQ_F_5040 + 12'(i - 2), 1'($random(seed)));
    end
    run_one(SHSEQ_F_5044, 1'b1);
    run_one(SHSEQ_F_5044, 1'b0);
    // no sequence, so no hold may start
    iSeq = 1'b0;
    repeat (32) @(negedge sysClk);
    $display("idle episode done");
    check({11'h000, fEn}, 12'h001, "fetch enable");
    check({6'h00, wCnt}, 12'h000, "count");
    check(12'(expQ.size()), 12'h000, "pending notes");
    finish_test();
  end
endmodule : shift_hold_sequencer_tb
`default_nettype wire

// *** dv/shseq_top_sva.sv ***
/*
  port checker for the shift-hold sequencer top.
  assumes phase count starts at T1.1 on the first edge after reset.
*/
`timescale 1ns/1ps
`default_nettype none
module shseq_top_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic iSeq,
  input wire logic [35:0] accum,
  input wire logic shiftStepA,
  input wire logic shiftStepB,
  input wire logic shiftStepC,
  input wire logic scaleFactor,
  input wire logic stallRelease,
  input wire logic fetchStallFirst,
  input wire logic fetchStallSecond,
  input wire logic [5:0] workingCount,
  input wire logic [11:0] heldFunc
);
  import shseq_pkg::*;
  logic [3:0] phaseCnt_r;
  logic diff_r;
  logic shiftCode;
  logic scaleRange;
  assign scaleRange = heldFunc >= SHSEQ_F_5040 && heldFunc <= SHSEQ_F_5047;
  assign shiftCode = heldFunc == SHSEQ_F_5026 || heldFunc == SHSEQ_F_5027 || scaleRange;
  // own step/phase copy, so a slip in the design's counter still shows
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phaseCnt_r <= 4'h0;
      diff_r <= 1'b0;
    end else begin
      phaseCnt_r <= phaseCnt_r + 4'h1;
      if (phaseCnt_r == 4'h5 && iSeq && !fetchStallFirst && !fetchStallSecond) begin
        diff_r <= accum[35] ^ accum[34];
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  stepa_clear_a: assert property (phaseCnt_r == 4'h6 && workingCount == 6'h00 |=> !shiftStepA)
    else $error("step a not clear after T2.3");
  stall1_set_a: assert property (phaseCnt_r == 4'hB && iSeq && shiftCode |=> fetchStallFirst)
    else $error("first stall not set at T3.4");
  scale_clear_a: assert property (phaseCnt_r == 4'hB && iSeq && scaleRange |=> !scaleFactor)
    else $error("scale factor not cleared");
  stepb_set_a: assert property (phaseCnt_r == 4'hC && fetchStallFirst && !fetchStallSecond |=>
    shiftStepB == !(heldFunc == SHSEQ_F_5044 && diff_r))
    else $error("step b wrong at T4.1");
  stall2_set_a: assert property (phaseCnt_r == 4'hE && fetchStallFirst |=> fetchStallSecond)
    else $error("second stall not set at T4.3");
  release_set_a: assert property (phaseCnt_r == 4'h0 && fetchStallFirst && fetchStallSecond
    && workingCount == 6'h00 |=> stallRelease)
    else $error("release not set at T1.1");
  stepb_clear_a: assert property (phaseCnt_r == 4'h0 && !shiftStepA |=> !shiftStepB)
    else $error("step b not cleared at T1.1");
  stepc_clear_a: assert property (phaseCnt_r == 4'h2 && !shiftStepB |=> !shiftStepC)
    else $error("step c not cleared at T1.3");
  stall1_clear_a: assert property (phaseCnt_r == 4'hD && stallRelease |=> !fetchStallFirst)
    else $error("first stall not cleared at T4.2");
  release_clear_a: assert property (phaseCnt_r == 4'hE && !fetchStallFirst |=> !stallRelease)
    else $error("release not cleared at T4.3");
  stall2_clear_a: assert property (phaseCnt_r == 4'h2 && !fetchStallFirst |=> !fetchStallSecond)
    else $error("second stall not cleared at T1.3");
  func_hold_a: assert property (fetchStallFirst || fetchStallSecond |=> $stable(heldFunc))
    else $error("function code changed while held");
endmodule : shseq_top_sva
bind shseq_top shseq_top_sva u_sva (.sys_clk(sys_clk), .nrst(nrst), .iSeq(iSeq), .accum(accum),
  .shiftStepA(shiftStepA), .shiftStepB(shiftStepB), .shiftStepC(shiftStepC),
  .scaleFactor(scaleFactor), .stallRelease(stallRelease), .fetchStallFirst(fetchStallFirst),
  .fetchStallSecond(fetchStallSecond), .workingCount(workingCount), .heldFunc(heldFunc));
`default_nettype wire

// *** rtl/shseq_pkg.sv ***
/*
  Shift-hold sequencer package: timing, function codes and widths.
  Assumes a 40 MHz sys_clk; each clock edge is one phase.
*/
package shseq_pkg;
  localparam int SHSEQ_PHASES = 4;
  localparam int SHSEQ_STEPS = 4;
  localparam int SHSEQ_FUNC_W = 12;
  localparam int SHSEQ_CNT_W = 6;
  localparam int SHSEQ_INSTR_W = 36;
  localparam int SHSEQ_ACC_W = 36;
  localparam int SHSEQ_ACC_MSB = 35;
  localparam int SHSEQ_ACC_NEXT = 34;
  // function codes, four octal digits each: 50:xx
  localparam logic [11:0] SHSEQ_F_5026 = 12'hA16;
  localparam logic [11:0] SHSEQ_F_5027 = 12'hA17;
  localparam logic [11:0] SHSEQ_F_5040 = 12'hA20;
  localparam logic [11:0] SHSEQ_F_5044 = 12'hA24;
  localparam logic [11:0] SHSEQ_F_5047 = 12'hA27;
  localparam logic [1:0] SHSEQ_STEP_RST = 2'h0;
  localparam logic [1:0] SHSEQ_PH_RST = 2'h0;
  // step/phase encodings (value = number - 1)
  localparam logic [1:0] SHSEQ_N1 = 2'h0;
  localparam logic [1:0] SHSEQ_N2 = 2'h1;
  localparam logic [1:0] SHSEQ_N3 = 2'h2;
  localparam logic [1:0] SHSEQ_N4 = 2'h3;
  localparam real SHSEQ_CLK_MHZ = 40.0;
  localparam real SHSEQ_ZERO_TIME_US = 4.0;
  localparam int SHSEQ_ZERO_CYCLES = int'(SHSEQ_ZERO_TIME_US * SHSEQ_CLK_MHZ);
endpackage : shseq_pkg

// *** rtl/shseq_timing.sv ***
/*
  Master clock phase and main step counter.
  Assumes run is synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module shseq_timing (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  shseq_timing_if.gen tim
);
  import shseq_pkg::*;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic [1:0] step_r;
  logic [1:0] step_nxt;

  always_comb begin
    phase_nxt = phase_r;
    step_nxt = step_r;
    if (run) begin
      phase_nxt = phase_r + 2'h1;
      if (phase_r == SHSEQ_N4) begin
        step_nxt = step_r + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= SHSEQ_PH_RST;
      step_r <= SHSEQ_STEP_RST;
    end else begin
      phase_r <= phase_nxt;
      step_r <= step_nxt;
    end
  end

  assign tim.phase = phase_r;
  assign tim.step = step_r;
endmodule : shseq_timing
`default_nettype wire

// *** rtl/shseq_timing_if.sv ***
/*
  Timing carrier between the phase generator and the sequencer.
  Assumes one driver (timing module) and one reader.
*/
`timescale 1ns/1ps
`default_nettype none
interface shseq_timing_if;
  logic [1:0] step;
  logic [1:0] phase;
  modport gen (output step, output phase);
  modport use_ (input step, input phase);
endinterface : shseq_timing_if
`default_nettype wire

// *** rtl/shseq_top.sv ***
/*
  Shift/scale instruction hold sequencer: fetch stalls and shift steps.
  Assumes instr, funcCode and accumulator inputs are same-clock logic.
*/
// Function
// - clear step ff a at T2.3 when working count is zero
// - set first fetch stall at T3.4 for 50:26, 50:27, 50:40-47
// - clear scale-factor ff at phase 4 of step 3 for 50:40-47
// - set step ff b at T4.1 unless scale with unequal top bits
// - at T4.3 set step ff c if step ff b set, and second stall from first stall
// - at T1.1 set stall release on zero count or unequal scale bits
// - at T1.1 clear step ff b when step ff a clear
// - at T1.3 clear step ff c when step ff b clear
// - at T4.2 clear first stall when stall release set
// - at T4.3 clear stall release once first stall clear
// - at T1.3 clear second stall once first stall clear
// - count from six low instruction bits; shift if nonzero unless scale with unequal bits
// - stalls hold sequence, block fetch, keep function and count
// - zero-count case takes one main cycle before release
// - four phases per master cycle, one shift place per cycle
`timescale 1ns/1ps
`default_nettype none
module shseq_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic iSeq,
  input wire logic [shseq_pkg::SHSEQ_FUNC_W-1:0] funcCode,
  input wire logic [shseq_pkg::SHSEQ_INSTR_W-1:0] instrWord,
  input wire logic [shseq_pkg::SHSEQ_ACC_W-1:0] accum,
  output logic shiftStepA,
  output logic shiftStepB,
  output logic shiftStepC,
  output logic scaleFactor,
  output logic stallRelease,
  output logic fetchStallFirst,
  output logic fetchStallSecond,
  output logic fetchEnable,
  output logic shiftPulse,
  output logic [shseq_pkg::SHSEQ_CNT_W-1:0] workingCount,
  output logic [shseq_pkg::SHSEQ_FUNC_W-1:0] heldFunc
);
  import shseq_pkg::*;

  shseq_timing_if tim ();

  shseq_timing u_timing (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(1'b1),
    .tim(tim)
  );

  function automatic logic at(input logic [1:0] s, input logic [1:0] p,
                              input logic [1:0] ws, input logic [1:0] wp);
    at = (s == ws) && (p == wp);
  endfunction : at

  function automatic logic inRange(input logic [11:0] f, input logic [11:0] lo,
                                   input logic [11:0] hi);
    inRange = (f >= lo) && (f <= hi);
  endfunction : inRange

  logic stepA_r, stepA_nxt;
  logic stepB_r, stepB_nxt;
  logic stepC_r, stepC_nxt;
  logic scale_r, scale_nxt;
  logic rel_r, rel_nxt;
  logic stall1_r, stall1_nxt;
  logic stall2_r, stall2_nxt;
  logic fetch_r, fetch_nxt;
  logic shift_r, shift_nxt;
  logic [SHSEQ_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [SHSEQ_FUNC_W-1:0] func_r, func_nxt;
  logic topUneq_r, topUneq_nxt;

  logic holding;
  logic scaleOp;
  logic shiftOp;
  logic noShift;
  logic [1:0] st;
  logic [1:0] ph;

  assign st = tim.step;
  assign ph = tim.phase;
  assign holding = stall1_r | stall2_r;
  assign scaleOp = (func_r == SHSEQ_F_5044);
  assign shiftOp = inRange(func_r, SHSEQ_F_5040, SHSEQ_F_5047);
  // no shift when count zero or scale finds top bits unequal
  assign noShift = (cnt_r == '0) || (scaleOp && topUneq_r);

  always_comb begin
    stepA_nxt = stepA_r;
    stepB_nxt = stepB_r;
    stepC_nxt = stepC_r;
    scale_nxt = scale_r;
    rel_nxt = rel_r;
    stall1_nxt = stall1_r;
    stall2_nxt = stall2_r;
    cnt_nxt = cnt_r;
    func_nxt = func_r;
    topUneq_nxt = topUneq_r;
    shift_nxt = 1'b0;
    // capture only while not stalled so function and count are retained
    if (iSeq && !holding && at(st, ph, SHSEQ_N2, SHSEQ_N2)) begin
      func_nxt = funcCode;
      cnt_nxt = instrWord[SHSEQ_CNT_W-1:0];
      topUneq_nxt = accum[SHSEQ_ACC_MSB] ^ accum[SHSEQ_ACC_NEXT];
    end
    if (iSeq && at(st, ph, SHSEQ_N2, SHSEQ_N3) && cnt_r == '0) begin
      stepA_nxt = 1'b0;
    end
    if (iSeq && at(st, ph, SHSEQ_N3, SHSEQ_N4)) begin
      if (func_r == SHSEQ_F_5026 || func_r == SHSEQ_F_5027 || shiftOp) begin
        stall1_nxt = 1'b1;
      end
      if (shiftOp) begin
        scale_nxt = 1'b0;
      end
    end
    // first hold cycle only; the second pass through T4.1 must not re-arm b
    if (stall1_r && !stall2_r && at(st, ph, SHSEQ_N4, SHSEQ_N1)) begin
      if (!(scaleOp && topUneq_r)) begin
        stepB_nxt = 1'b1;
      end
    end
    if (stall1_r && at(st, ph, SHSEQ_N4, SHSEQ_N3)) begin
      if (stepB_r) begin
        stepC_nxt = 1'b1;
      end
      stall2_nxt = 1'b1;
      if (!noShift) begin
        stepA_nxt = 1'b1;
      end
    end
    if (stall2_r && at(st, ph, SHSEQ_N1, SHSEQ_N1)) begin
      // only while first stall still up, else release re-arms after the hold
      if (noShift && stall1_r) begin
        rel_nxt = 1'b1;
      end
      if (!stepA_r) begin
        stepB_nxt = 1'b0;
      end
    end
    // one place per master cycle while shifting; count runs down
    if (stepA_r && at(st, ph, st, SHSEQ_N4)) begin
      shift_nxt = 1'b1;
      if (cnt_r != '0) begin
        cnt_nxt = cnt_r - 1'b1;
      end
      if (cnt_r == 6'h01) begin
        stepA_nxt = 1'b0;
        rel_nxt = 1'b1;
      end
    end
    if (!stepB_r && at(st, ph, SHSEQ_N1, SHSEQ_N3)) begin
      stepC_nxt = 1'b0;
    end
    if (rel_r && at(st, ph, SHSEQ_N4, SHSEQ_N2)) begin
      stall1_nxt = 1'b0;
    end
    if (!stall1_r && at(st, ph, SHSEQ_N4, SHSEQ_N3)) begin
      rel_nxt = 1'b0;
    end
    if (!stall1_r && at(st, ph, SHSEQ_N1, SHSEQ_N3)) begin
      stall2_nxt = 1'b0;
    end
  end

  // fetch blocked by either stall, registered on the same edge as the stall ffs
  assign fetch_nxt = !(stall1_nxt | stall2_nxt);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stepA_r <= 1'b0;
      stepB_r <= 1'b0;
      stepC_r <= 1'b0;
      scale_r <= 1'b0;
      rel_r <= 1'b0;
      stall1_r <= 1'b0;
      stall2_r <= 1'b0;
      fetch_r <= 1'b1;
      shift_r <= 1'b0;
      cnt_r <= '0;
      func_r <= '0;
      topUneq_r <= 1'b0;
    end else begin
      stepA_r <= stepA_nxt;
      stepB_r <= stepB_nxt;
      stepC_r <= stepC_nxt;
      scale_r <= scale_nxt;
      rel_r <= rel_nxt;
      stall1_r <= stall1_nxt;
      stall2_r <= stall2_nxt;
      fetch_r <= fetch_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      func_r <= func_nxt;
      topUneq_r <= topUneq_nxt;
    end
  end

  assign shiftStepA = stepA_r;
  assign shiftStepB = stepB_r;
  assign shiftStepC = stepC_r;
  assign scaleFactor = scale_r;
  assign stallRelease = rel_r;
  assign fetchStallFirst = stall1_r;
  assign fetchStallSecond = stall2_r;
  assign fetchEnable = fetch_r;
  assign shiftPulse = shift_r;
  assign workingCount = cnt_r;
  assign heldFunc = func_r;
endmodule : shseq_top
`default_nettype wire
